// *** hdl/dglm_pkg.sv ***
// constants for the pin unit: register offsets, field positions, reset values, timing
// assumes a 100 MHz core clock and an 8-bit register port
package dglm_pkg;
  localparam int          NUM_PINS        = 8;
  localparam int          NUM_PORTS       = 4;
  localparam int          FWD_SIGS        = 4;
  localparam int          BC_SLOTS        = 4;

  localparam logic [7:0]  REG_PIN_STATUS  = 8'h0e;
  localparam logic [7:0]  REG_IN_DISABLE  = 8'h0f;
  localparam logic [7:0]  REG_PIN0_CTRL   = 8'h10;
  localparam logic [7:0]  REG_PIN7_CTRL   = 8'h17;
  localparam logic [7:0]  REG_PORT_SEL    = 8'h4c;
  localparam logic [7:0]  REG_BC_LOW      = 8'h6e;
  localparam logic [7:0]  REG_BC_HIGH     = 8'h6f;
  localparam logic [7:0]  REG_PD_DISABLE  = 8'hbe;

  localparam logic [7:0]  RST_IN_DISABLE  = 8'h00;
  localparam logic [7:0]  RST_PD_DISABLE  = 8'h00;
  localparam logic [7:0]  RST_PIN_CTRL    = 8'h00;
  localparam logic [7:0]  RST_BC_CTRL     = 8'h00;
  localparam logic [1:0]  RST_PORT_SEL    = 2'h0;

  // pin output control fields
  localparam int          PC_OUT_EN       = 0;
  localparam int          PC_LEVEL        = 1;
  localparam int          PC_SRC_LSB      = 2;
  localparam int          PC_PORT_LSB     = 4;
  localparam int          PC_SIG_LSB      = 6;

  localparam logic [1:0]  SRC_LEVEL       = 2'h0;
  localparam logic [1:0]  SRC_FORWARD     = 2'h1;
  localparam logic [1:0]  SRC_FSYNC       = 2'h2;
  localparam logic [1:0]  SRC_AUX         = 2'h3;

  // back slot source codes: 0..7 pins, then the two frame-sync sources
  localparam logic [3:0]  SLOT_INT_FSYNC  = 4'h8;
  localparam logic [3:0]  SLOT_EXT_FSYNC  = 4'h9;
  localparam int          SLOT_SRC_W      = 10;

  // forward update spacing in frames for 1, 2 and 3-4 linked signals
  localparam logic [2:0]  FWD_DIV_ONE     = 3'h1;
  localparam logic [2:0]  FWD_DIV_TWO     = 3'h2;
  localparam logic [2:0]  FWD_DIV_MANY    = 3'h5;

  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          BC_BIT_NS       = 20;
  localparam int          BC_BIT_CYCLES   = (BC_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BC_FRAME_BITS   = 30;
endpackage

// *** hdl/dglm_fwd_hold.sv ***
// holds the forward-channel values of one receive port between updates
// assumes frame_tick pulses once per forward frame, synchronous to clk
`timescale 1ns/10ps
module dglm_fwd_hold
  import dglm_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                frame_tick,
  input  wire logic [2:0]          linked_count,
  input  wire logic [FWD_SIGS-1:0] fwd_value,
  output logic      [FWD_SIGS-1:0] held_value
);
  logic [2:0] frame_cnt;
  logic [2:0] div;

  function automatic logic [2:0] fwd_div(input logic [2:0] count);
    case (count)
      3'h1:    fwd_div = FWD_DIV_ONE;
      3'h2:    fwd_div = FWD_DIV_TWO;
      3'h3,
      3'h4:    fwd_div = FWD_DIV_MANY;
      default: fwd_div = 3'h0;
    endcase
  endfunction

  assign div = fwd_div(linked_count);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frame_cnt <= 3'h0;
    else if (div == 3'h0)
      frame_cnt <= 3'h0;
    else if (frame_tick)
    begin
      if (frame_cnt >= div - 3'h1)
        frame_cnt <= 3'h0;
      else
        frame_cnt <= frame_cnt + 3'h1;
    end
  end

  // nothing linked means nothing updates; the last value stays on the pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      held_value <= '0;
    else if (frame_tick && div != 3'h0 && frame_cnt >= div - 3'h1)
      held_value <= fwd_value;
  end
endmodule

// *** hdl/dglm_bc_sampler.sv ***
// back-channel slot sampler of one receive port: one sample per 30-bit frame
// assumes the link framer picks up bc_slot on the bc_frame pulse
`timescale 1ns/10ps
module dglm_bc_sampler
  import dglm_pkg::*;
#(
  parameter int BIT_CYCLES = BC_BIT_CYCLES
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [4*BC_SLOTS-1:0] slot_sel,
  input  wire logic [SLOT_SRC_W-1:0] sources,
  output logic                       bc_frame,
  output logic      [BC_SLOTS-1:0]   bc_slot
);
  localparam int FRAME_CYCLES = BC_FRAME_BITS * BIT_CYCLES;
  localparam int CW           = $clog2(FRAME_CYCLES + 1);

  logic [CW-1:0] cyc_cnt;
  logic          frame_end;

  assign frame_end = (cyc_cnt == CW'(FRAME_CYCLES - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cyc_cnt <= '0;
    else if (frame_end)
      cyc_cnt <= '0;
    else
      cyc_cnt <= cyc_cnt + CW'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bc_frame <= 1'b0;
    else
      bc_frame <= frame_end;
  end

  // a code above the source range sends zero rather than a stray bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bc_slot <= '0;
    else if (frame_end)
    begin
      for (int s = 0; s < BC_SLOTS; s++)
      begin
        if (slot_sel[4*s +: 4] < 4'(SLOT_SRC_W))
          bc_slot[s] <= sources[slot_sel[4*s +: 4]];
        else
          bc_slot[s] <= 1'b0;
      end
    end
  end
endmodule

// *** hdl/dglm_top.sv ***
// pin unit of the deserializer hub: eight pins, forward-channel mapping,
// back-channel slot mapping and the register port that controls them
// assumes pin inputs and link strobes are synchronous to clk
// Functional notes
// - up to four forward signals per port
// - any forward signal maps to any pin
// - update every 1, 2 or 5 frames
// - all pins start as inputs
// - four back slots per port, any pin
// - one pin may feed several slots
// - back-channel frame is thirty bits long
// - back slots sampled once per frame
// - internal or external frame sync on slots
// - frame sync or aux drives any pin
// - status reads each pin's level; an undriven pin with its input disabled reads low
// - per-pin input and pulldown disable, default on
// - two back-slot registers per receive port
// - input disable bit n is pin n
`timescale 1ns/10ps
module dglm_top
  import dglm_pkg::*;
#(
  parameter int NPORTS     = NUM_PORTS,
  parameter int BIT_CYCLES = BC_BIT_CYCLES
)
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_we,
  input  wire logic                       reg_re,
  output logic      [7:0]                 reg_rdata,
  output logic                            reg_rvalid,
  input  wire logic [NUM_PINS-1:0]        pin_in,
  output logic      [NUM_PINS-1:0]        pin_out,
  output logic      [NUM_PINS-1:0]        pin_oe,
  output logic      [NUM_PINS-1:0]        pin_in_en,
  output logic      [NUM_PINS-1:0]        pin_pd_en,
  input  wire logic [NPORTS-1:0]          fwd_frame,
  input  wire logic [3*NPORTS-1:0]        forward_linked_count,
  input  wire logic [FWD_SIGS*NPORTS-1:0] fwd_value,
  input  wire logic                       frame_sync_signal,
  input  wire logic                       ext_frame_sync,
  input  wire logic                       aux_ctrl,
  output logic      [NPORTS-1:0]          bc_frame,
  output logic      [BC_SLOTS*NPORTS-1:0] bc_slot
);
  logic [7:0]                 in_disable;
  logic [7:0]                 pd_disable;
  logic [7:0]                 pin_ctrl [NUM_PINS];
  logic [7:0]                 bc_low   [NPORTS];
  logic [7:0]                 bc_high  [NPORTS];
  logic [1:0]                 port_sel;
  logic [FWD_SIGS*NPORTS-1:0] fwd_held;
  logic [NUM_PINS-1:0]        pin_level;
  logic [NUM_PINS-1:0]        next_pin_out;
  logic [SLOT_SRC_W-1:0]      slot_sources;
  logic [7:0]                 next_rdata;

  function automatic logic is_pin_ctrl(input logic [7:0] addr);
    is_pin_ctrl = (addr >= REG_PIN0_CTRL) && (addr <= REG_PIN7_CTRL);
  endfunction

  function automatic logic [2:0] pin_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff      = addr - REG_PIN0_CTRL;
    pin_index = diff[2:0];
  endfunction

  // register writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_disable <= RST_IN_DISABLE;
      pd_disable <= RST_PD_DISABLE;
      port_sel   <= RST_PORT_SEL;
    end
    else if (reg_we)
    begin
      case (reg_addr)
        REG_IN_DISABLE: in_disable <= reg_wdata;
        REG_PD_DISABLE: pd_disable <= reg_wdata;
        REG_PORT_SEL:   port_sel   <= reg_wdata[1:0];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        pin_ctrl[i] <= RST_PIN_CTRL;
    end
    else if (reg_we && is_pin_ctrl(reg_addr))
      pin_ctrl[pin_index(reg_addr)] <= reg_wdata;
  end

  // the port select picks which receive port's slot pair the two offsets reach
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        bc_low[p]  <= RST_BC_CTRL;
        bc_high[p] <= RST_BC_CTRL;
      end
    end
    else if (reg_we && int'(port_sel) < NPORTS)
    begin
      if (reg_addr == REG_BC_LOW)
        bc_low[port_sel] <= reg_wdata;
      else if (reg_addr == REG_BC_HIGH)
        bc_high[port_sel] <= reg_wdata;
    end
  end

  // register reads, one cycle after the strobe; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (is_pin_ctrl(reg_addr))
      next_rdata = pin_ctrl[pin_index(reg_addr)];
    else
    begin
      case (reg_addr)
        REG_PIN_STATUS: next_rdata = pin_level;
        REG_IN_DISABLE: next_rdata = in_disable;
        REG_PD_DISABLE: next_rdata = pd_disable;
        REG_PORT_SEL:   next_rdata = {6'h00, port_sel};
        REG_BC_LOW:     next_rdata = (int'(port_sel) < NPORTS) ? bc_low[port_sel] : 8'h00;
        REG_BC_HIGH:    next_rdata = (int'(port_sel) < NPORTS) ? bc_high[port_sel] : 8'h00;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_re;
      if (reg_re)
        reg_rdata <= next_rdata;
    end
  end

  // forward channel: one holder per receive port
  for (genvar p = 0; p < NPORTS; p++)
  begin : g_fwd
    dglm_fwd_hold u_hold
    (
      .clk          (clk),
      .rst          (rst),
      .frame_tick   (fwd_frame[p]),
      .linked_count (forward_linked_count[3*p +: 3]),
      .fwd_value    (fwd_value[FWD_SIGS*p +: FWD_SIGS]),
      .held_value   (fwd_held[FWD_SIGS*p +: FWD_SIGS])
    );
  end

  // output source per pin
  always_comb
  begin
    next_pin_out = '0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      case (pin_ctrl[i][PC_SRC_LSB +: 2])
        SRC_LEVEL:   next_pin_out[i] = pin_ctrl[i][PC_LEVEL];
        SRC_FORWARD:
        begin
          if (int'(pin_ctrl[i][PC_PORT_LSB +: 2]) < NPORTS)
            next_pin_out[i] = fwd_held[FWD_SIGS * int'(pin_ctrl[i][PC_PORT_LSB +: 2])
                                       + int'(pin_ctrl[i][PC_SIG_LSB +: 2])];
          else
            next_pin_out[i] = 1'b0;
        end
        SRC_FSYNC:   next_pin_out[i] = frame_sync_signal;
        SRC_AUX:     next_pin_out[i] = aux_ctrl;
        default:     next_pin_out[i] = 1'b0;
      endcase
    end
  end

  // the driver only turns on once the input path is off; when the input path turns back on,
  // the driver stays on one cycle longer, so the pin is then driven and sampled together
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else
    begin
      pin_out <= next_pin_out;
      for (int i = 0; i < NUM_PINS; i++)
        pin_oe[i] <= pin_ctrl[i][PC_OUT_EN] & in_disable[i];
    end
  end

  assign pin_in_en = ~in_disable;
  assign pin_pd_en = ~pd_disable;

  // a driven pin reads back what it drives; a disabled input reads low
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
      pin_level[i] = pin_oe[i] ? pin_out[i] : (pin_in[i] & ~in_disable[i]);
  end

  assign slot_sources = {ext_frame_sync, frame_sync_signal, pin_level};

  // back channel: one sampler per receive port
  for (genvar p = 0; p < NPORTS; p++)
  begin : g_bc
    dglm_bc_sampler #(.BIT_CYCLES(BIT_CYCLES)) u_bc
    (
      .clk      (clk),
      .rst      (rst),
      .slot_sel ({bc_high[p], bc_low[p]}),
      .sources  (slot_sources),
      .bc_frame (bc_frame[p]),
      .bc_slot  (bc_slot[BC_SLOTS*p +: BC_SLOTS])
    );
  end
endmodule

// *** verification/dglm_assertions.sv ***
// checker for the pin unit, bound to every dglm_top
// assumes one clock domain and the active-high async reset
`timescale 1ns/10ps
module dglm_chk
  import dglm_pkg::*;
#(
  parameter int NPORTS     = NUM_PORTS,
  parameter int BIT_CYCLES = BC_BIT_CYCLES
)
(
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic                       reg_we,
  input wire logic                       reg_re,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       reg_rvalid,
  input wire logic [NUM_PINS-1:0]        pin_in,
  input wire logic [NUM_PINS-1:0]        pin_out,
  input wire logic [NUM_PINS-1:0]        pin_oe,
  input wire logic [NUM_PINS-1:0]        pin_in_en,
  input wire logic [NPORTS-1:0]          bc_frame,
  input wire logic [BC_SLOTS*NPORTS-1:0] bc_slot
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] bc_gap;
  logic       bc_seen;
  // the first frame after reset is skipped: its phase is not a full period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bc_gap  <= 8'h00;
      bc_seen <= 1'b0;
    end
    else if (bc_frame[0])
    begin
      bc_gap  <= 8'h00;
      bc_seen <= 1'b1;
    end
    else
      bc_gap <= bc_gap + 8'h01;
  end
  a_oe_needs_disable: assert property ((pin_oe & pin_in_en) == 8'h00)
    else $error("pin driven while input path enabled");
  a_reset_inputs: assert property ($past(rst) |-> pin_oe == 8'h00 && pin_in_en == 8'hff)
    else $error("pins not inputs after reset");
  a_read_answer: assert property (reg_re |=> reg_rvalid)
    else $error("read not answered");
  a_status_level: assert property (reg_re && reg_addr == REG_PIN_STATUS |=>
    reg_rdata == $past((pin_oe & pin_out) | (~pin_oe & pin_in & pin_in_en)))
    else $error("pin status wrong");
  a_in_disable_map: assert property (reg_we && reg_addr == REG_IN_DISABLE |=>
    pin_in_en == ~$past(reg_wdata)) else $error("input enable mismatch");
  a_pin0_output: assert property (reg_we && reg_addr == REG_PIN0_CTRL && !pin_in_en[0] |=>
    ##1 pin_oe[0] == $past(reg_wdata[0], 2)) else $error("pin0 drive mismatch");
  a_bc_frame_period: assert property (bc_frame[0] && bc_seen |->
    bc_gap == BC_FRAME_BITS * BIT_CYCLES - 1) else $error("back frame length wrong");
  a_bc_slot_hold: assert property (!bc_frame[0] |-> $stable(bc_slot[3:0]))
    else $error("slot changed between frames");
  c_bc_frame: cover property (bc_frame[2] && bc_slot[11:8] != 4'h0);
  c_read: cover property (reg_rvalid);
  c_drive: cover property (pin_oe[2] && pin_out[2]);
endmodule
bind dglm_top dglm_chk #(.NPORTS(NPORTS), .BIT_CYCLES(BIT_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_en(pin_in_en), .bc_frame(bc_frame),
  .bc_slot(bc_slot));

// *** verification/dglm_ser_model.sv ***
// remote serializer model: forward frames on all four ports
// assumes the bench sets count and values between frames, slowly
`timescale 1ns/10ps
module dglm_ser_model #(
  parameter int FRAME = 8
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  cnt,
  input  wire logic [3:0]  val,
  output logic      [3:0]  fwd_frame,
  output logic      [11:0] forward_linked_count,
  output logic      [15:0] fwd_value
);
  logic [3:0] ctr;
  assign forward_linked_count = {4{cnt}};
  // values change many frames apart, far under a quarter of the sample rate
  assign fwd_value = {4{val}};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctr       <= 4'h0;
      fwd_frame <= 4'h0;
    end
    else
    begin
      ctr       <= (ctr == 4'(FRAME - 1)) ? 4'h0 : ctr + 4'h1;
      fwd_frame <= {4{ctr == 4'(FRAME - 1)}};
    end
  end
endmodule

// *** verification/tb.sv ***
// self-checking bench for dglm_top with a serializer model on the forward side
// assumes BIT_CYCLES of 1, so a back frame is 30 clocks
`timescale 1ns/10ps
module tb
  import dglm_pkg::*;
;
  logic clk = 0, rst = 1, reg_we = 0, reg_re = 0, reg_rvalid;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, pin_in = 0;
  logic [7:0] pin_out, pin_oe, pin_in_en, pin_pd_en;
  logic fs = 0, ext = 0, aux = 0, lv = 0;
  logic [2:0] f_cnt = 0;
  logic [3:0] f_val = 0, fwd_frame, bc_frame;
  logic [11:0] flc;
  logic [15:0] fwd_value, bc_slot;
  int error_cnt = 0, num_checks = 0;
  always #5 clk = ~clk;
  dglm_ser_model u_ser (.clk(clk), .rst(rst), .cnt(f_cnt), .val(f_val),
    .fwd_frame(fwd_frame), .forward_linked_count(flc), .fwd_value(fwd_value));
  dglm_top #(.NPORTS(4), .BIT_CYCLES(1)) u_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in_en(pin_in_en), .pin_pd_en(pin_pd_en), .fwd_frame(fwd_frame),
    .forward_linked_count(flc), .fwd_value(fwd_value), .frame_sync_signal(fs),
    .ext_frame_sync(ext), .aux_ctrl(aux), .bc_frame(bc_frame), .bc_slot(bc_slot));
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
    @(posedge clk) reg_we <= 0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {reg_addr, reg_re} <= {a, 1'b1};
    @(posedge clk) reg_re <= 0;
    #1 chk(reg_rvalid, 1);
    chk(reg_rdata, e);
  endtask
  task t_reset;
    chk(pin_oe, 8'h00);
    chk(pin_in_en & pin_pd_en, 8'hff);
    rd(REG_IN_DISABLE, 8'h00);
    rd(8'h20, 8'h00);
    wr(REG_PIN_STATUS, 8'hff);
    rd(REG_PIN_STATUS, 8'h00);
    wr(REG_PD_DISABLE, 8'h81);
    chk(pin_pd_en, 8'h7e);
    rd(REG_PD_DISABLE, 8'h81);
  endtask
  task t_output;
    wr(8'h11, 8'h01);
    wr(REG_IN_DISABLE, 8'h31);
    wr(REG_PIN0_CTRL, 8'h03);
    wr(8'h14, 8'h09);
    wr(8'h15, 8'h0d);
    @(posedge clk) {pin_in, fs, aux} <= {8'h5a, 2'b10};
    repeat (3) @(posedge clk);
    chk(pin_oe, 8'h31);
    chk(pin_out & pin_oe, 8'h11);
    rd(REG_PIN_STATUS, 8'h5b);
    @(posedge clk) {fs, aux} <= 2'b01;
    repeat (3) @(posedge clk);
    chk(pin_out & pin_oe, 8'h21);
  endtask
  task t_fwd;
    logic [2:0] c[3] = '{3'h1, 3'h2, 3'h4};
    int d[3] = '{1, 2, 5};
    int n;
    wr(REG_IN_DISABLE, 8'h35);
    // pin2: forward source, port 3, signal 3
    wr(8'h12, 8'hf5);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk) {f_cnt, f_val} <= {3'h0, {4{~lv}}};
      repeat (20) @(posedge clk);
      chk(pin_out[2], lv);
      lv = ~lv;
      @(posedge clk) f_cnt <= c[k];
      n = 0;
      repeat (80)
      begin
        @(posedge clk);
        if (fwd_frame[3]) n++;
        if (pin_out[2] === lv) break;
      end
      chk(8'(n), 8'(d[k]));
    end
  endtask
  task wait_bc;
    repeat (2)
    begin
      repeat (70)
      begin
        @(posedge clk);
        if (bc_frame[2] === 1'b1) break;
      end
    end
  endtask
  task t_back;
    wr(REG_PORT_SEL, 8'h02);
    wr(REG_BC_LOW, 8'h33);
    wr(REG_BC_HIGH, 8'h98);
    rd(REG_BC_LOW, 8'h33);
    // pin and sync levels change a whole frame apart, well under a quarter of the sample rate
    @(posedge clk) {pin_in, fs, ext} <= {8'h08, 2'b10};
    wait_bc;
    chk(bc_slot[11:8], 4'h7);
    // port 0 keeps code 0 in every slot, and pin 0 is still driven high
    chk(bc_slot[3:0], 4'hf);
    @(posedge clk) {pin_in, fs, ext} <= {8'h00, 2'b01};
    wait_bc;
    chk(bc_slot[11:8], 4'h8);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 t_reset;
    t_output;
    t_fwd;
    t_back;
    stop_test;
  end
  initial
  begin
    #60000;
    error_cnt++;
    stop_test;
  end
endmodule
